// ---- pkg/frg_pkg.sv ----
// Purpose: Shared constants and types for the flash rewrite guard
// Assumes: 32-bit APB, 20-bit code flash byte address, 1 KB blocks
// Notes: Offsets are byte addresses on the APB

package frg_pkg;
    // =====================================================
    // Register map
    // =====================================================
    localparam int APB_AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00; // Control
    localparam logic [7:0] OFS_WIN = 8'h04; // Window bounds
    localparam logic [7:0] OFS_STAT = 8'h08; // Live state
    localparam logic [7:0] OFS_ISTAT = 8'h0C; // Sticky events
    localparam logic [7:0] OFS_IMASK = 8'h10; // Event mask

    // Control bits
    localparam int CTL_SP_EN = 0; // Self-programming on
    localparam int CTL_SWAP = 1; // Boot swap request
    localparam int CTL_BC0P = 2; // Cluster 0 lock, set only

    // Window fields
    localparam int BLK_W = 8;
    localparam int WIN_ST_LSB = 0;
    localparam int WIN_END_LSB = 8;
    localparam logic [BLK_W-1:0] WIN_ST_RST = 8'h00;
    localparam logic [BLK_W-1:0] WIN_END_RST = 8'hFF;

    // Status bits
    localparam int STA_SP = 0;
    localparam int STA_BOOT1 = 1;
    localparam int STA_SWPEND = 2;
    localparam int STA_BC0P = 3;
    localparam int STA_SERIAL = 4;
    localparam int STA_LOADED = 5;

    // Interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_DENY = 0; // Rewrite blocked
    localparam int IRQ_REFUSE = 1; // Entry refused
    localparam int IRQ_SET = 2; // Setting stored
    localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

    // =====================================================
    // Flash geometry
    // =====================================================
    localparam int FL_AW = 20;
    localparam int BLK_LSB = 10; // 1 KB blocks
    localparam int BC_LSB = 12; // 4 KB boot cluster

    // =====================================================
    // Setting store layout
    // =====================================================
    localparam int NV_AW = 1;
    localparam int NV_DW = 16;
    localparam logic [NV_AW-1:0] NV_FLAGS = 1'h0;
    localparam logic [NV_AW-1:0] NV_WIN = 1'h1;
    localparam int NVF_SWAP = 0;
    localparam int NVF_BC0P = 1;

    // Settings loader, runs after each reset
    typedef enum logic [0:0] {
        ST_LOAD = 1'b0,
        ST_RUN = 1'b1
    } frg_state_e;
endpackage : frg_pkg

// ---- rtl/frg_nv_store.sv ----
// Purpose: Small setting store that keeps its words across rst_n
// Assumes: One write and one registered read port
// Notes: Contents start from shipped defaults at power-up only

`timescale 1ns/1ps

module frg_nv_store
    import frg_pkg::*;
#(
    parameter int AW = NV_AW,
    parameter int DW = NV_DW
) (
    input wire logic clock,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_ff
);
    // =====================================================
    // Storage
    // =====================================================
    // Shipped defaults: no swap, no lock, open window, set once at power-up
    // Declared here so that only the write port ever assigns the array
    logic [DW-1:0] mem_ff [2**AW] = '{NV_WIN: DW'({WIN_END_RST, WIN_ST_RST}), default: '0};

    // Write port, untouched by reset
    always_ff @(posedge clock) begin
        if (we) begin
            mem_ff[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clock) begin
        rdata_ff <= mem_ff[raddr];
    end
endmodule : frg_nv_store

// ---- rtl/frg_guard.sv ----
// Purpose: Write/erase guard for code flash during rewriting
// Assumes: APB registers, flash requests from the same clock
// Notes: Settings reload from the store after each reset

`timescale 1ns/1ps

module frg_guard
    import frg_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System state
    input wire logic cpu_on_subclk,
    input wire logic fast_osc_halt,
    input wire logic serial_mode_pin,
    // Flash rewrite request
    input wire logic flash_req,
    input wire logic [FL_AW-1:0] flash_addr,
    input wire logic flash_is_data,
    output logic resp_valid,
    output logic resp_grant,
    // Boot and interrupt
    output logic boot_cluster1,
    output logic irq
);
    // =====================================================
    // Helpers
    // =====================================================
    // Block number of a flash address
    function automatic logic [BLK_W-1:0] blk_of(
        input logic [FL_AW-1:0] a);
        blk_of = a[BLK_LSB +: BLK_W];
    endfunction : blk_of

    // Address falls in boot cluster 0
    function automatic logic in_bc0(input logic [FL_AW-1:0] a);
        in_bc0 = (a[FL_AW-1:BC_LSB] == '0);
    endfunction : in_bc0

    // Inclusive window test
    function automatic logic in_win(
        input logic [BLK_W-1:0] b,
        input logic [BLK_W-1:0] lo,
        input logic [BLK_W-1:0] hi);
        in_win = (b >= lo) && (b <= hi);
    endfunction : in_win

    // =====================================================
    // State
    // =====================================================
    frg_state_e state_ff; // Loader state
    logic [1:0] ld_cnt_ff; // Load step
    logic ser_s1_ff; // Serial pin sync, stage 1
    logic ser_s2_ff; // Serial pin sync, stage 2
    logic sp_active_ff; // Self-programming live
    logic swap_boot_ff; // Boot cluster in use
    logic swap_nv_ff; // Stored swap setting
    logic bc0_prot_ff; // Cluster 0 lock
    logic [BLK_W-1:0] win_st_ff; // Window start block
    logic [BLK_W-1:0] win_end_ff; // Window end block
    logic [IRQ_W-1:0] istat_ff; // Sticky events
    logic [IRQ_W-1:0] imask_ff; // Event mask
    logic [31:0] prdata_ff; // Read data
    logic resp_valid_ff; // Answer strobe
    logic resp_grant_ff; // Answer value
    logic [NV_DW-1:0] nv_rdata; // Store read data

    // =====================================================
    // Bus decode
    // =====================================================
    logic acc; // Access phase
    logic wr; // Write access
    logic mapped; // Known offset
    logic cfg_ok; // Settings may change
    logic ctrl_wr; // Control write
    logic win_wr; // Window write
    logic cfg_wr; // Accepted setting write
    logic sp_ask; // Entry requested
    logic sp_bad; // Entry not allowed
    logic [IRQ_W-1:0] ev_set; // Events this cycle
    logic [IRQ_W-1:0] ev_clr; // Clears this cycle

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_WIN)
        || (paddr == OFS_STAT) || (paddr == OFS_ISTAT)
        || (paddr == OFS_IMASK);
    assign cfg_ok = (state_ff == ST_RUN) && (sp_active_ff || ser_s2_ff);
    assign ctrl_wr = wr && (paddr == OFS_CTRL);
    assign win_wr = wr && (paddr == OFS_WIN) && cfg_ok;
    assign cfg_wr = ctrl_wr && cfg_ok
        && (pwdata[CTL_SWAP] || pwdata[CTL_BC0P]);
    assign sp_ask = ctrl_wr && pwdata[CTL_SP_EN] && !sp_active_ff;
    assign sp_bad = cpu_on_subclk || fast_osc_halt
        || (state_ff != ST_RUN);
    assign ev_clr = (wr && (paddr == OFS_ISTAT))
        ? pwdata[IRQ_W-1:0] : '0;

    // Zero wait, errors on unknown offsets or locked window writes
    assign pready = 1'b1;
    assign pslverr = acc && (!mapped
        || (pwrite && (paddr == OFS_WIN) && !cfg_ok));
    assign prdata = prdata_ff;

    // =====================================================
    // Serial mode pin synchroniser
    // =====================================================
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ser_s1_ff <= 1'b0;
            ser_s2_ff <= 1'b0;
        end else begin
            ser_s1_ff <= serial_mode_pin;
            ser_s2_ff <= ser_s1_ff;
        end
    end

    // =====================================================
    // Setting store and loader
    // =====================================================
    logic nv_we; // Store write
    logic [NV_AW-1:0] nv_waddr; // Store write word
    logic [NV_DW-1:0] nv_wdata; // Store write data
    logic [NV_AW-1:0] nv_raddr; // Store read word
    logic [NV_DW-1:0] flags_w; // Flags word image

    always_comb begin
        flags_w = '0;
        flags_w[NVF_SWAP] = swap_nv_ff ^ pwdata[CTL_SWAP];
        flags_w[NVF_BC0P] = bc0_prot_ff | pwdata[CTL_BC0P];
    end

    assign nv_we = win_wr || cfg_wr;
    assign nv_waddr = win_wr ? NV_WIN : NV_FLAGS;
    assign nv_wdata = win_wr ? pwdata[NV_DW-1:0] : flags_w;
    assign nv_raddr = (ld_cnt_ff == 2'h0) ? NV_FLAGS : NV_WIN;

    frg_nv_store #(
        .AW(NV_AW),
        .DW(NV_DW)
    ) u_store (
        .clock(clock),
        .we(nv_we),
        .waddr(nv_waddr),
        .wdata(nv_wdata),
        .raddr(nv_raddr),
        .rdata_ff(nv_rdata)
    );

    // Loader steps through the store once after reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= ST_LOAD;
            ld_cnt_ff <= 2'h0;
        end else begin
            unique case (state_ff)
                ST_LOAD: begin
                    ld_cnt_ff <= ld_cnt_ff + 2'h1;
                    if (ld_cnt_ff == 2'h2) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    ld_cnt_ff <= ld_cnt_ff;
                end
            endcase
        end
    end

    // boot cluster latched at load only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            swap_boot_ff <= 1'b0;
        end else if (state_ff == ST_LOAD && ld_cnt_ff == 2'h1) begin
            swap_boot_ff <= nv_rdata[NVF_SWAP];
        end
    end

    // Flags: loaded, then changed by accepted writes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            swap_nv_ff <= 1'b0;
            bc0_prot_ff <= 1'b0;
        end else if (state_ff == ST_LOAD && ld_cnt_ff == 2'h1) begin
            swap_nv_ff <= nv_rdata[NVF_SWAP];
            bc0_prot_ff <= nv_rdata[NVF_BC0P];
        end else if (cfg_wr) begin
            swap_nv_ff <= flags_w[NVF_SWAP];
            bc0_prot_ff <= flags_w[NVF_BC0P];
        end
    end

    // Window bounds
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            win_st_ff <= WIN_ST_RST;
            win_end_ff <= WIN_END_RST;
        end else if (state_ff == ST_LOAD && ld_cnt_ff == 2'h2) begin
            win_st_ff <= nv_rdata[WIN_ST_LSB +: BLK_W];
            win_end_ff <= nv_rdata[WIN_END_LSB +: BLK_W];
        end else if (win_wr) begin
            win_st_ff <= pwdata[WIN_ST_LSB +: BLK_W];
            win_end_ff <= pwdata[WIN_END_LSB +: BLK_W];
        end
    end

    // =====================================================
    // Self-programming entry
    // =====================================================
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sp_active_ff <= 1'b0;
        end else if (sp_bad) begin
            sp_active_ff <= 1'b0;
        end else if (ctrl_wr) begin
            sp_active_ff <= pwdata[CTL_SP_EN];
        end
    end

    // =====================================================
    // Rewrite check
    // =====================================================
    logic chk_ok; // Request allowed
    logic [BLK_W-1:0] req_blk; // Request block

    assign req_blk = blk_of(flash_addr);

    always_comb begin
        if (state_ff != ST_RUN) begin
            // Settings not yet loaded
            chk_ok = 1'b0;
        end else if (flash_is_data) begin
            chk_ok = 1'b1;
        end else if (bc0_prot_ff && in_bc0(flash_addr)) begin
            chk_ok = 1'b0;
        end else if (ser_s2_ff) begin
            chk_ok = 1'b1;
        end else if (sp_active_ff) begin
            chk_ok = in_win(req_blk, win_st_ff, win_end_ff);
        end else begin
            // Normal run, no rewriting
            chk_ok = 1'b0;
        end
    end

    // Answer one cycle after each request
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            resp_valid_ff <= 1'b0;
            resp_grant_ff <= 1'b0;
        end else begin
            resp_valid_ff <= flash_req;
            resp_grant_ff <= flash_req && chk_ok;
        end
    end

    assign resp_valid = resp_valid_ff;
    assign resp_grant = resp_grant_ff;
    assign boot_cluster1 = swap_boot_ff;

    // =====================================================
    // Interrupts
    // =====================================================
    always_comb begin
        ev_set = '0;
        ev_set[IRQ_DENY] = flash_req && !chk_ok;
        ev_set[IRQ_REFUSE] = sp_ask && sp_bad;
        ev_set[IRQ_SET] = nv_we;
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            istat_ff <= '0;
        end else begin
            istat_ff <= (istat_ff & ~ev_clr) | ev_set;
        end
    end

    // Mask register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            imask_ff <= IMASK_RST;
        end else if (wr && (paddr == OFS_IMASK)) begin
            imask_ff <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(istat_ff & imask_ff);

    // =====================================================
    // Read data, prepared in the setup cycle
    // =====================================================
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_ff <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= '0;
            unique case (paddr)
                OFS_CTRL: begin
                    prdata_ff[CTL_SP_EN] <= sp_active_ff;
                    prdata_ff[CTL_BC0P] <= bc0_prot_ff;
                end
                OFS_WIN: begin
                    prdata_ff[WIN_ST_LSB +: BLK_W] <= win_st_ff;
                    prdata_ff[WIN_END_LSB +: BLK_W] <= win_end_ff;
                end
                OFS_STAT: begin
                    prdata_ff[STA_SP] <= sp_active_ff;
                    prdata_ff[STA_BOOT1] <= swap_boot_ff;
                    prdata_ff[STA_SWPEND] <= swap_nv_ff ^ swap_boot_ff;
                    prdata_ff[STA_BC0P] <= bc0_prot_ff;
                    prdata_ff[STA_SERIAL] <= ser_s2_ff;
                    prdata_ff[STA_LOADED] <= (state_ff == ST_RUN);
                end
                OFS_ISTAT: begin
                    prdata_ff[IRQ_W-1:0] <= istat_ff;
                end
                OFS_IMASK: begin
                    prdata_ff[IRQ_W-1:0] <= imask_ff;
                end
                default: begin
                    prdata_ff <= '0;
                end
            endcase
        end
    end

    // =====================================================
    // Checks
    // =====================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_subclk_refuse: assert property (
        cpu_on_subclk |=> !sp_active_ff)
        else $error("self-programming live on subsystem clock");

    chk_dflash_pass: assert property (
        flash_req && flash_is_data && state_ff == ST_RUN
        |=> resp_valid_ff && resp_grant_ff)
        else $error("data flash request denied");

    chk_bc0_lock: assert property (
        flash_req && !flash_is_data && bc0_prot_ff
        && in_bc0(flash_addr) |=> resp_valid_ff && !resp_grant_ff)
        else $error("cluster 0 rewrite granted while locked");

    chk_serial_open: assert property (
        flash_req && ser_s2_ff && state_ff == ST_RUN
        && !(bc0_prot_ff && in_bc0(flash_addr)) |=> resp_grant_ff)
        else $error("serial rewrite denied");

    chk_window_deny: assert property (
        flash_req && !flash_is_data && !ser_s2_ff
        && !in_win(req_blk, win_st_ff, win_end_ff)
        |=> !resp_grant_ff)
        else $error("rewrite outside window granted");

    chk_window_edge: assert property (
        flash_req && !flash_is_data && !ser_s2_ff && sp_active_ff
        && state_ff == ST_RUN && !(bc0_prot_ff && in_bc0(flash_addr))
        && (req_blk == win_st_ff || req_blk == win_end_ff)
        |=> resp_grant_ff)
        else $error("window bound block denied");

    chk_boot_stable: assert property (
        state_ff == ST_RUN && $past(state_ff) == ST_RUN
        |-> $stable(swap_boot_ff))
        else $error("boot cluster changed outside reload");

    chk_swap_toggle: assert property (
        cfg_wr && pwdata[CTL_SWAP] |=> swap_nv_ff != $past(swap_nv_ff))
        else $error("swap request did not toggle setting");

    chk_window_set: assert property (
        win_wr |=> win_st_ff == $past(pwdata[WIN_ST_LSB +: BLK_W])
        && win_end_ff == $past(pwdata[WIN_END_LSB +: BLK_W]))
        else $error("window bounds not updated");

    chk_store_write: assert property (
        cfg_wr || win_wr |-> nv_we ##1 istat_ff[IRQ_SET])
        else $error("setting change not stored");
endmodule : frg_guard

// ---- test/frg_flash_model.sv ----
// Purpose: Code flash array seen from the guard's far side
// Assumes: One request per cycle, answer one cycle later
// Notes: Counts rewrites the guard let through

`timescale 1ns/1ps

module frg_flash_model (
    input wire logic clock,
    input wire logic flash_req,
    input wire logic [19:0] flash_addr,
    input wire logic resp_valid,
    input wire logic resp_grant,
    output logic [7:0] rewrites
);
    // =====================================================
    // Array state
    // =====================================================
    logic [19:0] held_addr; // Address of request in flight
    logic [7:0] blk_hits [256]; // Rewrites seen per block

    initial rewrites = 8'h00;

    // Latch request, apply it only when granted
    always @(posedge clock) begin
        if (flash_req) begin
            held_addr <= flash_addr;
        end
        if (resp_valid && resp_grant) begin
            rewrites <= rewrites + 8'h01;
            blk_hits[held_addr[17:10]] <= blk_hits[held_addr[17:10]] + 8'h01;
        end
    end
endmodule : frg_flash_model

// ---- test/tb_frg_guard.sv ----
// Purpose: Self-checking bench for the flash rewrite guard
// Assumes: APB master and flash requester driven by the bench
// Notes: Row table first, then hand-written cases

`timescale 1ns/1ps

module tb_frg_guard
    import frg_pkg::*;
;
    // =====================================================
    // Signals
    // =====================================================
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr;
    logic cpu_on_subclk = 1'b0, fast_osc_halt = 1'b0, serial_mode_pin = 1'b0;
    logic flash_req = 1'b0, flash_is_data = 1'b0;
    logic [19:0] flash_addr = 20'h0;
    logic resp_valid, resp_grant, boot_cluster1, irq;
    logic [7:0] rewrites;
    int errors = 0, check_count = 0, exp_grants = 0;

    // Ordinary request rows
    typedef struct packed {
        logic [19:0] addr;
        logic dat;
        logic gnt;
    } frg_row_s;
    frg_row_s rows [6] = '{'{20'h00FFF, 1'b0, 1'b0}, '{20'h01000, 1'b0, 1'b1},
        '{20'h01BFF, 1'b0, 1'b1}, '{20'h01C00, 1'b0, 1'b0},
        '{20'hF1000, 1'b1, 1'b1}, '{20'h01400, 1'b0, 1'b1}};

    always #2.5 clock = ~clock;

    frg_guard u_frg_guard (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_on_subclk(cpu_on_subclk), .fast_osc_halt(fast_osc_halt),
        .serial_mode_pin(serial_mode_pin), .flash_req(flash_req), .flash_addr(flash_addr),
        .flash_is_data(flash_is_data), .resp_valid(resp_valid), .resp_grant(resp_grant),
        .boot_cluster1(boot_cluster1), .irq(irq));

    frg_flash_model u_frg_flash_model (.clock(clock), .flash_req(flash_req),
        .flash_addr(flash_addr), .resp_valid(resp_valid), .resp_grant(resp_grant),
        .rewrites(rewrites));

    // =====================================================
    // Tasks
    // =====================================================
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready at an edge
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(rdat, exp);
    endtask : rd_chk

    // Poll a status bit under a bounded count
    task wait_stat(input int b);
        for (int i = 0; i < 20; i++) begin
            apb(OFS_STAT, 1'b0, 32'h0);
            if (rdat[b] === 1'b1) break;
        end
        chk(32'(rdat[b]), 32'h1);
    endtask : wait_stat

    // One rewrite request, answer looked at one cycle later
    task fl(input logic [19:0] a, input logic d, input logic g);
        @(posedge clock);
        flash_req <= 1'b1; flash_addr <= a; flash_is_data <= d;
        @(posedge clock);
        flash_req <= 1'b0;
        #1;
        chk({30'h0, resp_valid, resp_grant}, {30'h0, 1'b1, g});
        if (g) exp_grants++;
    endtask : fl

    task do_reset();
        rst_n <= 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        wait_stat(STA_LOADED);
    endtask : do_reset

    task close_out();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // =====================================================
    // Sequence
    // =====================================================
    initial begin
        #100000;
        errors++;
        close_out();
    end

    initial begin
        do_reset();
        // voltage mode is chosen by software, the guard ignores it
        // software gates interrupts through the mask
        apb(OFS_IMASK, 1'b1, 32'h7);
        apb(OFS_CTRL, 1'b1, 32'h1);
        rd_chk(OFS_STAT, 32'h21);
        apb(OFS_WIN, 1'b1, 32'h0604);
        chk(32'(rerr), 32'h0);
        rd_chk(OFS_WIN, 32'h0604);
        foreach (rows[i]) fl(rows[i].addr, rows[i].dat, rows[i].gnt);
        $display("test rows done");
        chk(32'(irq), 32'h1);
        apb(OFS_ISTAT, 1'b1, 32'h7);
        rd_chk(OFS_ISTAT, 32'h0);
        apb(OFS_IMASK, 1'b1, 32'h0);
        fl(20'h02000, 1'b0, 1'b0);
        chk(32'(irq), 32'h0);
        rd_chk(OFS_ISTAT, 32'h1);
        $display("test irq done");
        cpu_on_subclk <= 1'b1;
        rd_chk(OFS_STAT, 32'h20);
        apb(OFS_CTRL, 1'b1, 32'h1);
        rd_chk(OFS_STAT, 32'h20);
        rd_chk(OFS_ISTAT, 32'h3);
        cpu_on_subclk <= 1'b0;
        $display("test subclock done");
        apb(OFS_CTRL, 1'b1, 32'h1);
        apb(OFS_WIN, 1'b1, 32'h0600);
        apb(OFS_CTRL, 1'b1, 32'h5);
        fl(20'h00800, 1'b0, 1'b0);
        fl(20'h00FFF, 1'b0, 1'b0);
        fl(20'h01000, 1'b0, 1'b1);
        $display("test lock done");
        apb(OFS_CTRL, 1'b1, 32'h0);
        serial_mode_pin <= 1'b1;
        wait_stat(STA_SERIAL);
        fl(20'h0F000, 1'b0, 1'b1);
        fl(20'h00000, 1'b0, 1'b0);
        apb(OFS_WIN, 1'b1, 32'h0705);
        chk(32'(rerr), 32'h0);
        $display("test serial done");
        // new boot image in place before swap
        apb(OFS_CTRL, 1'b1, 32'h2);
        apb(OFS_STAT, 1'b0, 32'h0);
        chk({30'h0, rdat[STA_SWPEND], rdat[STA_BOOT1]}, 32'h2);
        chk(32'(boot_cluster1), 32'h0);
        do_reset();
        chk(32'(boot_cluster1), 32'h1);
        rd_chk(OFS_WIN, 32'h0705);
        apb(OFS_STAT, 1'b0, 32'h0);
        chk({29'h0, rdat[STA_BC0P], rdat[STA_SWPEND], rdat[STA_BOOT1]}, 32'h5);
        $display("test swap done");
        rd_chk(8'h14, 32'h0);
        chk(32'(rerr), 32'h1);
        rd_chk(OFS_CTRL, 32'h4);
        // Leave serial mode, halt the fast oscillator
        serial_mode_pin <= 1'b0;
        fast_osc_halt <= 1'b1;
        repeat (3) @(posedge clock);
        apb(OFS_WIN, 1'b1, 32'h0102);
        chk(32'(rerr), 32'h1);
        rd_chk(OFS_WIN, 32'h0705);
        apb(OFS_CTRL, 1'b1, 32'h1);
        rd_chk(OFS_STAT, 32'h2A);
        rd_chk(OFS_ISTAT, 32'h2);
        fast_osc_halt <= 1'b0;
        $display("test refuse done");
        // Request while the settings still load is denied
        rst_n <= 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        fl(20'hF1000, 1'b1, 1'b0);
        wait_stat(STA_LOADED);
        chk(32'(boot_cluster1), 32'h1);
        $display("test early request done");
        repeat (2) @(posedge clock);
        chk(32'(rewrites), 32'(exp_grants));
        $display("test tail done");
        close_out();
    end
endmodule : tb_frg_guard
